/* sfg_regs.vh */
// Constants for the SDI fallback generator control block
`ifndef SFG_REGS_VH
`define SFG_REGS_VH
// Clock rate in kHz (100 MHz)
`define SFG_CLK_KHZ 100000
// Gray hold time in seconds
`define SFG_GRAY_S 7
// Continuous valid time before learning, in seconds
`define SFG_LEARN_S 5
// Longest changeover blank, in milliseconds
`define SFG_SWITCH_MAX_MS 2000
// Blank time actually used at a changeover, in milliseconds
`define SFG_SWITCH_MS 10
// Cycle counts derived from the times
`define SFG_GRAY_CYC (`SFG_GRAY_S * `SFG_CLK_KHZ * 1000)
`define SFG_LEARN_CYC (`SFG_LEARN_S * `SFG_CLK_KHZ * 1000)
`define SFG_SWITCH_CYC (`SFG_SWITCH_MS * `SFG_CLK_KHZ)
// Output source encoding
`define SFG_SRC_BLANK 2'h0
`define SFG_SRC_PASS 2'h1
`define SFG_SRC_GRAY 2'h2
`define SFG_SRC_IMAGE 2'h3
// Format codes: bit 0 selects 1080 lines when set
`define SFG_FMT_1080_BIT 0
// Image sizes
`define SFG_W720 12'h500
`define SFG_H720 12'h2D0
`define SFG_W1080 12'h780
`define SFG_H1080 12'h438
// Status output polarity choices
`define SFG_POL_OFF 2'h0
`define SFG_POL_VALID 2'h1
`define SFG_POL_MISSING 2'h2
// Reset value of the stored format and rate
`define SFG_FMT_RST 8'h01
`endif

/* sfg_overlay.v */
// Moving red box position generator for the overlay
`timescale 1ns/100ps
module sfg_overlay #(
  parameter STEP_CYC = 1000000,
  parameter BOX = 12'h080
) (
  clk,
  sys_rst,
  ce,
  run,
  frame_w,
  frame_h,
  box_x,
  box_y
);
  input wire clk;
  input wire sys_rst;
  input wire ce;
  input wire run;
  input wire [11:0] frame_w;
  input wire [11:0] frame_h;
  output reg [11:0] box_x;
  output reg [11:0] box_y;

  reg [31:0] tick_q;
  reg dir_x_q;
  reg dir_y_q;
  wire step;

  assign step = (tick_q == STEP_CYC - 1);

  // ****************************************
  // Bounce the box inside the frame
  // ****************************************
  // Fixed step period and size keep motion slow and constant
  always @(posedge clk) begin
    if (sys_rst) begin
      tick_q <= 32'h00000000;
      box_x <= 12'h000;
      box_y <= 12'h000;
      dir_x_q <= 1'b0;
      dir_y_q <= 1'b0;
    end else if (ce) begin
      if (!run || step) begin
        tick_q <= 32'h00000000;
      end else begin
        tick_q <= tick_q + 32'h00000001;
      end
      if (run && step) begin
        if (!dir_x_q) begin
          if (box_x + BOX >= frame_w) dir_x_q <= 1'b1;
          else box_x <= box_x + 12'h001;
        end else begin
          if (box_x == 12'h000) dir_x_q <= 1'b0;
          else box_x <= box_x - 12'h001;
        end
        if (!dir_y_q) begin
          if (box_y + BOX >= frame_h) dir_y_q <= 1'b1;
          else box_y <= box_y + 12'h001;
        end else begin
          if (box_y == 12'h000) dir_y_q <= 1'b0;
          else box_y <= box_y - 12'h001;
        end
      end
    end
  end
endmodule

/* sfg_ctrl.v */
// Output source control for the SDI fallback generator
// Summary of operation
// - Pass-through mode forwards a valid selected input to coax and optical outputs at once.
// - On input loss, output solid gray for about seven seconds.
// - After gray, output the stored 720 or 1080 still image by stored format.
// - Changeovers may blank the output, but never longer than two seconds.
// - Reference-only mode uses input just for timing, always outputs the generated image.
// - Reference-only mode still reports input valid when the selected input is valid.
// - Forwarded input keeps the source format and rate.
// - Auto mode stores input format and rate after five seconds of continuous valid.
// - Only supported format and rate combinations are learned.
// - The generator always runs at the stored format and rate.
// - Locked mode never updates the stored format and rate.
// - Overlay setting draws a slowly moving fixed red box on the image.
// - Overlay applies only to the generated image, never to pass-through.
// - The auxiliary input is ignored.
// - Status output high on valid, or high on missing, by polarity setting.
// - Generated image is 1280x720 or 1920x1080 per stored format.
// - A setting picks coax or optical input; only that one counts.
`timescale 1ns/100ps
`include "sfg_regs.vh"

// ****************************************
// Behaviour notes
// ****************************************
// Every change of output source except gray to still image passes through a short blank, so the
// downstream receiver relocks once instead of seeing a torn frame.
// The blank stays far below the two-second ceiling; a longer SWITCH_CYC
// buys relock margin at the price of a longer visible outage.
// Gray is shown only after a forwarded input is lost. At power-up, or when
// reference-only mode is chosen, the still image follows the blank.
// Learning needs an unbroken valid stretch: a single dropped cycle restarts
// the count, so a flickering source is never learned.
// The stored format arrives from nonvolatile memory while nv_format_ok is
// high and overwrites the working copy on every such cycle, except one in which a learned format is written.
// Format bit 0 picks the 1080-line raster; the other bits carry the rate.
// The overlay flag rises only while the still image is on air, so a
// forwarded input is never drawn over.
// The generator is told to lock to the selected input whenever it is valid,
// in either mode, and runs free from its own timebase otherwise.
// aux_input reaches the pins but is deliberately left unused.
// Clock enable low freezes every register, the timers included.

module sfg_ctrl #(
  parameter GRAY_CYC = `SFG_GRAY_CYC,
  parameter LEARN_CYC = `SFG_LEARN_CYC,
  parameter SWITCH_CYC = `SFG_SWITCH_CYC,
  parameter OVL_STEP_CYC = 1000000
) (
  clk,
  sys_rst,
  ce,
  input_select,
  reference_only,
  format_locked,
  overlay_enable,
  status_polarity,
  aux_input,
  coax_valid,
  coax_format,
  opt_valid,
  opt_format,
  nv_format,
  nv_format_ok,
  nv_write,
  nv_write_data,
  output_source,
  route_from_optical,
  gen_format,
  gen_width,
  gen_height,
  gen_genlock,
  overlay_on,
  overlay_x,
  overlay_y,
  high_when_input_valid,
  status_output
);
  // Clock, reset and enable
  input wire clk;
  input wire sys_rst;
  input wire ce;

  // Configuration settings
  input wire input_select;
  input wire reference_only;
  input wire format_locked;
  input wire overlay_enable;
  input wire [1:0] status_polarity;
  input wire aux_input;

  // Receiver status from the two inputs
  input wire coax_valid;
  input wire [7:0] coax_format;
  input wire opt_valid;
  input wire [7:0] opt_format;

  // Nonvolatile format memory
  input wire [7:0] nv_format;
  input wire nv_format_ok;
  output reg nv_write;
  output reg [7:0] nv_write_data;

  // Output stage and generator controls
  output reg [1:0] output_source;
  output reg route_from_optical;
  output reg [7:0] gen_format;
  output reg [11:0] gen_width;
  output reg [11:0] gen_height;
  output reg gen_genlock;
  output reg overlay_on;
  output reg [11:0] overlay_x;
  output reg [11:0] overlay_y;

  // Status indications
  output reg high_when_input_valid;
  output reg status_output;

  // ****************************************
  // States, one-hot
  // ****************************************
  localparam ST_BLANK = 4'h1;
  localparam ST_PASS = 4'h2;
  localparam ST_GRAY = 4'h4;
  localparam ST_IMAGE = 4'h8;

  // Supported format/rate table; codes outside it are never learned
  function fmt_supported;
    input [7:0] f;
    begin
      fmt_supported = (f[7:4] == 4'h0) && (f[3:1] <= 3'h5);
    end
  endfunction

  // Forwarding is wanted only in pass-through mode with a valid input
  function want_pass;
    input valid;
    input ref_only;
    begin
      want_pass = valid && !ref_only;
    end
  endfunction

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [31:0] tmr_q;
  reg [31:0] learn_q;
  reg [7:0] fmt_q;
  reg learned_q;
  reg sel_valid;
  reg [7:0] sel_fmt;
  wire tmr_done_gray;
  wire tmr_done_sw;
  wire [11:0] ovl_x;
  wire [11:0] ovl_y;

  // Only the selected input counts; aux_input is not used at all
  always @* begin
    sel_valid = input_select ? opt_valid : coax_valid;
    sel_fmt = input_select ? opt_format : coax_format;
  end

  // Both timers count from the last state change; one counter serves all states
  assign tmr_done_gray = (tmr_q >= GRAY_CYC - 1);
  assign tmr_done_sw = (tmr_q >= SWITCH_CYC - 1);

  // ****************************************
  // Source selection state machine
  // ****************************************
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_BLANK: begin
        // Short bounded blank at each changeover
        // Reference-only mode never enters gray from the blank: no forwarded input was lost
        if (tmr_done_sw) begin
          if (want_pass(sel_valid, reference_only)) st_d = ST_PASS;
          else if (learned_q && !reference_only) st_d = ST_GRAY;
          else st_d = ST_IMAGE;
        end
      end
      ST_PASS: begin
        if (!want_pass(sel_valid, reference_only)) st_d = ST_BLANK;
      end
      ST_GRAY: begin
        if (want_pass(sel_valid, reference_only)) st_d = ST_BLANK;
        else if (tmr_done_gray) st_d = ST_IMAGE;
      end
      ST_IMAGE: begin
        if (want_pass(sel_valid, reference_only)) st_d = ST_BLANK;
      end
      default: st_d = ST_BLANK;
    endcase
  end

  // Gray only follows the loss of a forwarded input
  // learned_q marks that a forwarded input was on air since the last still image
  always @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_BLANK;
      tmr_q <= 32'h00000000;
      learned_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      if (st_d != st_q) tmr_q <= 32'h00000000;
      else tmr_q <= tmr_q + 32'h00000001;
      if (st_q == ST_PASS) learned_q <= 1'b1;
      else if (st_q == ST_IMAGE) learned_q <= 1'b0;
    end
  end

  // ****************************************
  // Format learning
  // ****************************************
  // Counter restarts on any dropout so only continuous signal counts
  always @(posedge clk) begin
    if (sys_rst) begin
      learn_q <= 32'h00000000;
      nv_write <= 1'b0;
      nv_write_data <= `SFG_FMT_RST;
      fmt_q <= `SFG_FMT_RST;
    end else if (ce) begin
      nv_write <= 1'b0;
      if (nv_format_ok) fmt_q <= nv_format;
      if (!sel_valid || format_locked) begin
        learn_q <= 32'h00000000;
      end else if (learn_q < LEARN_CYC - 1) begin
        learn_q <= learn_q + 32'h00000001;
      end else if (learn_q == LEARN_CYC - 1) begin
        // Parking the count past the end gives one write per valid stretch
        learn_q <= LEARN_CYC;
        // Writing only on a change spares the memory's write endurance
        if (fmt_supported(sel_fmt) && sel_fmt != fmt_q) begin
          nv_write <= 1'b1;
          nv_write_data <= sel_fmt;
          fmt_q <= sel_fmt;
        end
      end
    end
  end

  // Box position runs with the setting alone; only the on-air flag looks at the state
  sfg_overlay #(
    .STEP_CYC(OVL_STEP_CYC),
    .BOX(12'h080)
  ) u_ovl (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .run(overlay_enable),
    .frame_w(gen_width),
    .frame_h(gen_height),
    .box_x(ovl_x),
    .box_y(ovl_y)
  );

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      output_source <= `SFG_SRC_BLANK;
      route_from_optical <= 1'b0;
      gen_format <= `SFG_FMT_RST;
      gen_width <= `SFG_W1080;
      gen_height <= `SFG_H1080;
      gen_genlock <= 1'b0;
      overlay_on <= 1'b0;
      overlay_x <= 12'h000;
      overlay_y <= 12'h000;
      high_when_input_valid <= 1'b0;
      status_output <= 1'b0;
    end else if (ce) begin
      case (st_q)
        ST_PASS: output_source <= `SFG_SRC_PASS;
        ST_GRAY: output_source <= `SFG_SRC_GRAY;
        ST_IMAGE: output_source <= `SFG_SRC_IMAGE;
        default: output_source <= `SFG_SRC_BLANK;
      endcase
      route_from_optical <= input_select;
      gen_format <= fmt_q;
      // Image size follows the stored format
      if (fmt_q[`SFG_FMT_1080_BIT]) begin
        gen_width <= `SFG_W1080;
        gen_height <= `SFG_H1080;
      end else begin
        gen_width <= `SFG_W720;
        gen_height <= `SFG_H720;
      end
      gen_genlock <= sel_valid;
      overlay_on <= overlay_enable && (st_q == ST_IMAGE);
      overlay_x <= ovl_x;
      overlay_y <= ovl_y;
      high_when_input_valid <= sel_valid;
      // Codes 0 and 3 hold the status output low
      case (status_polarity)
        `SFG_POL_VALID: status_output <= sel_valid;
        `SFG_POL_MISSING: status_output <= !sel_valid;
        default: status_output <= 1'b0;
      endcase
    end
  end
endmodule

/* sfg_ctrl_asserts.sv */
// Checker for the SDI fallback generator control block
`timescale 1ns/100ps
`include "sfg_regs.vh"
module sfg_ctrl_asserts #(
  parameter GRAY_CYC = 20,
  parameter SWITCH_CYC = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire ce,
  input wire input_select,
  input wire reference_only,
  input wire format_locked,
  input wire [1:0] status_polarity,
  input wire coax_valid,
  input wire opt_valid,
  input wire nv_write,
  input wire [7:0] nv_write_data,
  input wire [1:0] output_source,
  input wire [7:0] gen_format,
  input wire [11:0] gen_width,
  input wire overlay_on,
  input wire high_when_input_valid,
  input wire status_output
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  // A frozen clock enable holds every output, so checks pause with it
  default disable iff (sys_rst || !ce);
  localparam int SW_MAX = SWITCH_CYC + 6;
  wire sv = input_select ? opt_valid : coax_valid;
  reg [31:0] gray_q;
  // Counts one gray stretch; a counter avoids a huge repetition
  always @(posedge clk) begin
    if (sys_rst) gray_q <= 32'h0;
    else if (ce) gray_q <= (output_source == `SFG_SRC_GRAY) ? gray_q + 32'h1 : 32'h0;
  end
  AST_IND_VALID: assert property (sv[*3] |-> high_when_input_valid)
    else $error("valid indication missing");
  AST_STAT_VALID: assert property ((status_polarity == 2'h1 && sv)[*3] |-> status_output)
    else $error("status not high on valid");
  AST_STAT_MISS: assert property ((status_polarity == 2'h2 && !sv)[*3] |-> status_output)
    else $error("status not high on missing");
  AST_REF_NO_PASS: assert property (reference_only[*3] |-> output_source != `SFG_SRC_PASS)
    else $error("input forwarded in reference mode");
  AST_NO_PASS_LOST: assert property (!sv[*3] |-> output_source != `SFG_SRC_PASS)
    else $error("forwarding without valid input");
  AST_OVL_IMAGE: assert property (overlay_on |-> output_source == `SFG_SRC_IMAGE)
    else $error("overlay outside image");
  AST_SIZE: assert property ($stable(gen_format)[*3] |->
    gen_width == (gen_format[0] ? `SFG_W1080 : `SFG_W720))
    else $error("width does not match format");
  AST_LOCK_NO_WR: assert property (format_locked[*2] |-> !nv_write)
    else $error("write while locked");
  AST_NV_OK: assert property (nv_write |-> nv_write_data[7:4] == 4'h0 && nv_write_data[3:1] <= 3'h5)
    else $error("unsupported format written");
  AST_BLANK_MAX: assert property ($rose(output_source == `SFG_SRC_BLANK) |->
    ##[1:SW_MAX] output_source != `SFG_SRC_BLANK)
    else $error("changeover blank too long");
  AST_GRAY_MAX: assert property (gray_q <= GRAY_CYC + 2)
    else $error("gray held too long");
  C_GRAY: cover property (output_source == `SFG_SRC_GRAY);
  C_WRITE: cover property (nv_write);
  C_OVL: cover property (overlay_on);
endmodule
bind sfg_ctrl sfg_ctrl_asserts #(.GRAY_CYC(GRAY_CYC), .SWITCH_CYC(SWITCH_CYC)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .input_select(input_select), .reference_only(reference_only),
  .format_locked(format_locked), .status_polarity(status_polarity), .coax_valid(coax_valid),
  .opt_valid(opt_valid), .nv_write(nv_write), .nv_write_data(nv_write_data),
  .output_source(output_source), .gen_format(gen_format), .gen_width(gen_width),
  .overlay_on(overlay_on), .high_when_input_valid(high_when_input_valid), .ce(ce),
  .status_output(status_output));

/* sfg_src_model.sv */
// Upstream source and format memory model
`timescale 1ns/100ps
module sfg_src_model (
  input wire clk,
  input wire sys_rst,
  input wire [1:0] src_on,
  input wire [7:0] src_fmt,
  input wire nv_write,
  input wire [7:0] nv_write_data,
  output reg coax_valid = 1'b0,
  output reg [7:0] coax_format = 8'h00,
  output reg opt_valid = 1'b0,
  output reg [7:0] opt_format = 8'h00,
  output reg [7:0] nv_format = 8'h00,
  output reg nv_format_ok = 1'b0
);
  reg [7:0] junk_q = 8'h5A;
  reg [1:0] load_q = 2'h2;
  // Lost inputs show a moving format, never the last good one
  always @(posedge clk) begin
    junk_q <= junk_q + 8'h35;
    coax_valid <= src_on[0];
    opt_valid <= src_on[1];
    coax_format <= src_on[0] ? src_fmt : junk_q;
    opt_format <= src_on[1] ? src_fmt : ~junk_q;
    if (sys_rst) begin
      load_q <= 2'h2;
      nv_format_ok <= 1'b0;
    end else begin
      nv_format_ok <= load_q != 2'h0;
      if (load_q != 2'h0) load_q <= load_q - 2'h1;
      if (nv_write) nv_format <= nv_write_data;
    end
  end
endmodule

/* tb_sfg_ctrl.sv */
// Self-checking testbench for the SDI fallback generator control block
`timescale 1ns/100ps
module tb_sfg_ctrl;
  localparam GRAY = 20;
  localparam LEARN = 10;
  localparam SW = 3;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg input_select = 1'b0, reference_only = 1'b0, format_locked = 1'b0;
  reg overlay_enable = 1'b0, aux_input = 1'b0, ce = 1'b1;
  reg [1:0] status_polarity = 2'h1, src_on = 2'h0;
  reg [7:0] src_fmt = 8'h00;
  wire coax_valid, opt_valid, nv_format_ok, nv_write, route_from_optical;
  wire overlay_on, high_when_input_valid, status_output, gen_genlock;
  wire [7:0] coax_format, opt_format, nv_format, nv_write_data, gen_format;
  wire [1:0] output_source;
  wire [11:0] gen_width, gen_height, overlay_x, overlay_y;
  integer fail_count = 0, check_count = 0, wr_count = 0, n, i;
  reg [7:0] wr_data = 8'h00;
  reg [11:0] x0, y0;
  // ****************
  // Harness
  // ****************
  sfg_ctrl #(.GRAY_CYC(GRAY), .LEARN_CYC(LEARN), .SWITCH_CYC(SW), .OVL_STEP_CYC(2)) DUT (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .input_select(input_select),
    .reference_only(reference_only), .format_locked(format_locked),
    .overlay_enable(overlay_enable), .status_polarity(status_polarity), .aux_input(aux_input),
    .coax_valid(coax_valid), .coax_format(coax_format), .opt_valid(opt_valid),
    .opt_format(opt_format), .nv_format(nv_format), .nv_format_ok(nv_format_ok),
    .nv_write(nv_write), .nv_write_data(nv_write_data), .output_source(output_source),
    .route_from_optical(route_from_optical), .gen_format(gen_format), .gen_width(gen_width),
    .gen_height(gen_height), .gen_genlock(gen_genlock), .overlay_on(overlay_on),
    .overlay_x(overlay_x), .overlay_y(overlay_y), .high_when_input_valid(high_when_input_valid),
    .status_output(status_output));
  sfg_src_model u_src (.clk(clk), .sys_rst(sys_rst), .src_on(src_on), .src_fmt(src_fmt),
    .nv_write(nv_write), .nv_write_data(nv_write_data), .coax_valid(coax_valid),
    .coax_format(coax_format), .opt_valid(opt_valid), .opt_format(opt_format),
    .nv_format(nv_format), .nv_format_ok(nv_format_ok));
  initial begin
    forever #5 clk = ~clk;
  end
  // Log every memory write pulse
  always @(posedge clk) begin
    if (nv_write === 1'b1) begin
      wr_count = wr_count + 1;
      wr_data = nv_write_data;
    end
  end
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task chk(input [11:0] got, input [11:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for a source; the design may take a changeover blank first
  task wait_src(input [1:0] s, input integer k);
    begin
      n = 0;
      while (output_source !== s && n < k) begin
        step(1);
        n = n + 1;
      end
      chk({10'h0, output_source}, {10'h0, s});
    end
  endtask
  // New valid period on the coax input with a given format
  task feed(input [7:0] f);
    begin
      src_on = 2'h0;
      step(SW + 4);
      src_fmt = f;
      src_on = 2'h1;
      step(LEARN + 8);
    end
  endtask
  function [11:0] exp_stat(input [1:0] p, input v);
    exp_stat = {11'h0, (p == 2'h1) ? v : (p == 2'h2) ? !v : 1'b0};
  endfunction
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    conclude;
  end
  initial begin
    void'($urandom(16));
    step(4);
    sys_rst = 1'b0;
    wait_src(2'h3, SW + 10);
    chk(gen_width, 12'h500);
    chk(gen_height, 12'h2D0);
    overlay_enable = 1'b1;
    step(3);
    chk({11'h0, overlay_on}, 12'h1);
    // The box steps one pixel every two cycles here, down and right at first
    x0 = overlay_x;
    y0 = overlay_y;
    step(4);
    chk(overlay_x - x0, 12'h002);
    chk(overlay_y - y0, 12'h002);
    src_fmt = 8'h03;
    src_on = 2'h1;
    wait_src(2'h1, SW + 6);
    chk({11'h0, overlay_on}, 12'h0);
    step(LEARN + 4);
    chk(wr_count[11:0], 12'h1);
    chk({4'h0, wr_data}, 12'h003);
    chk(gen_width, 12'h780);
    src_on = 2'h0;
    wait_src(2'h2, SW + 4);
    n = 0;
    while (output_source === 2'h2 && n < 100) begin
      step(1);
      n = n + 1;
    end
    chk({11'h0, n >= GRAY - 1 && n <= GRAY + 2}, 12'h1);
    chk({10'h0, output_source}, 12'h3);
    format_locked = 1'b1;
    feed(8'h02);
    chk(wr_count[11:0], 12'h1);
    format_locked = 1'b0;
    feed(8'h1C);
    chk(wr_count[11:0], 12'h1);
    feed(8'h02);
    chk({4'h0, gen_format}, 12'h002);
    reference_only = 1'b1;
    step(SW + 6);
    chk({10'h0, output_source}, 12'h3);
    chk({11'h0, high_when_input_valid}, 12'h1);
    input_select = 1'b1;
    step(SW + 6);
    chk({11'h0, high_when_input_valid}, 12'h0);
    chk({11'h0, route_from_optical}, 12'h1);
    // Clock enable low must freeze the indication although the input changes
    ce = 1'b0;
    input_select = 1'b0;
    step(5);
    chk({11'h0, high_when_input_valid}, 12'h0);
    ce = 1'b1;
    step(2);
    chk({11'h0, high_when_input_valid}, 12'h1);
    // Random mix; every polarity code comes round in turn
    for (i = 0; i < 40; i = i + 1) begin
      src_on = $urandom % 4;
      src_fmt = $urandom % 16;
      input_select = $urandom % 2;
      reference_only = $urandom % 2;
      format_locked = $urandom % 2;
      aux_input = $urandom % 2;
      status_polarity = i % 4;
      step(10);
      chk({11'h0, status_output}, exp_stat(status_polarity, src_on[input_select]));
      chk({11'h0, gen_genlock}, {11'h0, src_on[input_select]});
    end
    conclude;
  end
endmodule
